// ==== src/adhc_consts.svh ====
// constants for the audio decimation and dc-removal chain
// assumes inclusion by bare name from the hpf and chain modules
`ifndef ADHC_CONSTS_SVH
`define ADHC_CONSTS_SVH

// reference clock
`define ADHC_REF_CLK_HZ      125000000
// dc-removal high-pass corner as a fraction of the output rate, in millionths
`define ADHC_HPF_FC_PPM      250
// one-pole coefficient 1 - exp(-2*pi*fc/fs) scaled by 2**ADHC_HPF_FRAC
`define ADHC_HPF_FRAC        16
`define ADHC_HPF_ALPHA       103
// output rate above which the record path runs wide band
`define ADHC_WIDE_RATE_HZ    176400
`define ADHC_WIDE_BW_HZ      80000
`define ADHC_WIDE_PERIOD_CYC (`ADHC_REF_CLK_HZ / `ADHC_WIDE_RATE_HZ)
// linear-phase design targets, in tenths of a dB or of a sample
`define ADHC_LP_RIPPLE_CDB   5
`define ADHC_LP_PASS_EDGE    454
`define ADHC_LP_8K_STOP_DB   727
`define ADHC_LP_8K_FAR_DB    812
`define ADHC_LP_8K_GD        171
`define ADHC_LP_16K_STOP_DB  733
`define ADHC_LP_16K_FAR_DB   950
`define ADHC_LP_16K_GD       157
`define ADHC_LP_24K_STOP_DB  730
`define ADHC_LP_24K_FAR_DB   964
`define ADHC_LP_24K_GD       166
// default channel count and widths
`define ADHC_CHANNELS        4
`define ADHC_MOD_W           8
`define ADHC_ACC_GROW        10
`define ADHC_PERIOD_W        16

`endif

// ==== src/adhc_pkg.sv ====
// types shared by the decimation chain and its high-pass stage
// assumes nothing beyond the constants header
package adhc_pkg;
  typedef enum logic [1:0] {
    ADHC_ST_IDLE = 2'h1,
    ADHC_ST_RUN  = 2'h2
  } adhc_state_t;

  typedef enum logic [1:0] {
    ADHC_SET_LIN = 2'h1,
    ADHC_SET_LOW = 2'h2
  } adhc_set_t;
endpackage : adhc_pkg

// ==== src/adhc_hpf.sv ====
// first-order dc-removal high-pass stage for one channel
// assumes one sample pulse per output frame, several cycles apart
`timescale 1ns/100ps
`include "adhc_consts.svh"

module adhc_hpf
  import adhc_pkg::*;
#(
  parameter int W     = 18,
  parameter int FRAC  = `ADHC_HPF_FRAC,
  parameter int ALPHA = `ADHC_HPF_ALPHA
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                in_valid_i,
  input  wire logic signed [W-1:0] in_data_i,
  output logic                     out_valid_o,
  output logic signed [W-1:0]      out_data_o
);
  localparam int YW = W + FRAC + 2;
  // signed limits keep the clamp compare signed; an unsigned limit would pin negatives high
  localparam logic signed [YW-FRAC-1:0] Y_MAX = (YW-FRAC)'((64'sd1 <<< (W-1)) - 64'sd1);
  localparam logic signed [YW-FRAC-1:0] Y_MIN = -Y_MAX;

  typedef struct packed {
    logic signed [W-1:0]  x1;
    logic signed [YW-1:0] y;
    logic signed [W-1:0]  out;
    logic                 valid;
  } adhc_hpf_st_t;

  adhc_hpf_st_t st_reg, st_next;
  logic signed [W:0]       diff;
  logic signed [YW+8:0]    prod;
  logic signed [YW-1:0]    y_new;
  logic signed [YW-FRAC-1:0] y_int;

  generate
    if (ALPHA < 1 || ALPHA > 255 || W < 4) begin : g_bad
      $error("adhc_hpf: coefficient or width out of range");
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    st_next.valid = 1'b0;
    diff  = (W+1)'(in_data_i) - (W+1)'(st_reg.x1);
    prod  = (YW+9)'(st_reg.y) * (YW+9)'(ALPHA);
    // y[n] = x[n] - x[n-1] + (1 - alpha) * y[n-1]
    y_new = st_reg.y + (YW'(diff) <<< FRAC) - YW'(prod >>> FRAC);
    y_int = y_new[YW-1:FRAC];
    if (in_valid_i) begin
      st_next.x1    = in_data_i;
      st_next.y     = y_new;
      st_next.valid = 1'b1;
      // clamp keeps a full-scale step from wrapping the output word
      if (y_int > Y_MAX) begin
        st_next.out = {1'b0, {(W-1){1'b1}}};
      end else if (y_int < Y_MIN) begin
        st_next.out = {1'b1, {(W-2){1'b0}}, 1'b1};
      end else begin
        st_next.out = y_int[W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_valid_o = st_reg.valid;
  assign out_data_o  = st_reg.out;

  a_hpf_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    in_valid_i |=> out_valid_o ##1 !out_valid_o)
    else $error("hpf output not one cycle after input");
  a_hpf_dc_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    in_valid_i && in_data_i == st_reg.x1 && st_reg.y == '0 |=> out_data_o == '0)
    else $error("hpf passes a settled dc level");
endmodule : adhc_hpf

// ==== src/adhc_chain.sv ====
// record-path decimation and dc-removal chain for all converter channels
// assumes modulator words and frame sync arrive synchronous to the reference clock,
// frame sync high for at least one cycle and low for at least four per frame
`timescale 1ns/100ps
`include "adhc_consts.svh"

//////////////////////////////////////////////////////////////////////////////
module adhc_chain
  import adhc_pkg::*;
#(
  parameter int CH   = `ADHC_CHANNELS,
  parameter int MW   = `ADHC_MOD_W,
  parameter int GROW = `ADHC_ACC_GROW,
  parameter int PW   = `ADHC_PERIOD_W
) (
  input  wire logic              REF_CLK_I,
  input  wire logic              RESET_I,
  input  wire logic              MASTER_MODE_I,
  input  wire logic              FILTER_SELECT_PIN_I,
  input  wire logic              FRAME_SYNC_I,
  input  wire logic              MOD_VALID_I,
  input  wire logic [CH*MW-1:0]  MOD_DATA_I,
  output logic [CH*(MW+GROW)-1:0] SAMPLES_O,
  output logic                   SAMPLE_VALID_O,
  output logic                   LOW_LATENCY_O,
  output logic                   WIDE_BAND_O
);
  localparam int AW = MW + GROW;
  localparam logic [PW-1:0] WIDE_CYC = PW'(`ADHC_WIDE_PERIOD_CYC);

  typedef struct packed {
    adhc_state_t              state;
    adhc_set_t                set;
    logic                     wide;
    logic                     fs_prev;
    logic [PW-1:0]            period;
    logic [CH-1:0][AW-1:0]    acc;
    logic [CH-1:0][AW-1:0]    h1;
    logic [CH-1:0][AW-1:0]    h2;
    logic [CH-1:0][AW-1:0]    dec;
    logic                     dec_valid;
    logic [CH*AW-1:0]         samples;
    logic                     out_valid;
  } adhc_chain_st_t;

  adhc_chain_st_t st_reg, st_next;
  logic                  frame_edge;
  logic                  wide_now;
  adhc_set_t             set_now;
  logic [CH-1:0][AW-1:0] mod_ext;
  logic [CH-1:0][AW+1:0] fir_sum;
  logic [CH-1:0]         hpf_valid;
  logic [CH-1:0][AW-1:0] hpf_data;

  generate
    if (CH < 1 || MW < 2 || GROW < 1 || PW < 12) begin : g_bad
      $error("adhc_chain: parameters out of range");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // frame tracking and filter-set choice

  assign frame_edge = FRAME_SYNC_I && !st_reg.fs_prev;
  // period is measured in reference cycles; a short frame means a high output rate
  assign wide_now   = (st_reg.period <= WIDE_CYC);

  always_comb begin
    if (MASTER_MODE_I) begin
      // pin is a clock-ratio strap in master mode, never a filter choice
      set_now = ADHC_SET_LIN;
    end else if (FILTER_SELECT_PIN_I) begin
      set_now = ADHC_SET_LOW;
    end else begin
      set_now = ADHC_SET_LIN;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // decimation datapath

  always_comb begin
    st_next = st_reg;
    st_next.fs_prev   = FRAME_SYNC_I;
    st_next.dec_valid = 1'b0;
    st_next.out_valid = 1'b0;
    for (int c = 0; c < CH; c++) begin
      mod_ext[c] = {{GROW{MOD_DATA_I[c*MW+MW-1]}}, MOD_DATA_I[c*MW +: MW]};
      // symmetric 1-2-1 taps give exact linear phase at one sample of delay
      fir_sum[c] = {{2{st_reg.acc[c][AW-1]}}, st_reg.acc[c]}
                 + {st_reg.h1[c][AW-1], st_reg.h1[c], 1'b0}
                 + {{2{st_reg.h2[c][AW-1]}}, st_reg.h2[c]};
    end
    if (st_reg.period != {PW{1'b1}}) begin
      st_next.period = st_reg.period + PW'(1);
    end
    for (int c = 0; c < CH; c++) begin
      if (MOD_VALID_I) begin
        st_next.acc[c] = st_reg.acc[c] + mod_ext[c];
      end
    end
    if (frame_edge) begin
      st_next.period = PW'(1);
      st_next.wide   = wide_now;
      st_next.set    = set_now;
      for (int c = 0; c < CH; c++) begin
        // a word arriving on the edge opens the new frame
        st_next.acc[c] = MOD_VALID_I ? mod_ext[c] : '0;
      end
      unique case (st_reg.state)
        ADHC_ST_IDLE: begin
          // first frame is partial, so it is dropped rather than output
          st_next.state = ADHC_ST_RUN;
        end
        ADHC_ST_RUN: begin
          st_next.dec_valid = 1'b1;
          for (int c = 0; c < CH; c++) begin
            st_next.h1[c] = st_reg.acc[c];
            st_next.h2[c] = st_reg.h1[c];
            if (set_now == ADHC_SET_LOW) begin
              st_next.dec[c] = st_reg.acc[c];
            end else if (wide_now) begin
              // pure delay keeps the band flat to the output nyquist rate
              st_next.dec[c] = st_reg.h1[c];
            end else begin
              // stop-band and delay figures stay targets here
              st_next.dec[c] = fir_sum[c][AW+1:2];
            end
          end
        end
      endcase
    end
    // all channels leave in the same cycle from one shared strobe
    if (hpf_valid[0]) begin
      st_next.samples   = hpf_data;
      st_next.out_valid = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      st_reg       <= '0;
      st_reg.state <= ADHC_ST_IDLE;
      st_reg.set   <= ADHC_SET_LIN;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shared high-pass, one copy per channel with one coefficient

  generate
    for (genvar g = 0; g < CH; g++) begin : g_hpf
      adhc_hpf #(
        .W     (AW),
        .FRAC  (`ADHC_HPF_FRAC),
        .ALPHA (`ADHC_HPF_ALPHA)
      ) u_hpf (
        .clk_i       (REF_CLK_I),
        .rst_i       (RESET_I),
        .in_valid_i  (st_reg.dec_valid),
        .in_data_i   (st_reg.dec[g]),
        .out_valid_o (hpf_valid[g]),
        .out_data_o  (hpf_data[g])
      );
    end
  endgenerate

  assign SAMPLES_O      = st_reg.samples;
  assign SAMPLE_VALID_O = st_reg.out_valid;
  // one-hot code: bit 1 marks the low-latency set, so the pin is a bare flop
  assign LOW_LATENCY_O  = st_reg.set[1];
  assign WIDE_BAND_O    = st_reg.wide;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  a_frame_output: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    frame_edge && st_reg.state == ADHC_ST_RUN |-> ##3 SAMPLE_VALID_O)
    else $error("no sample three cycles after frame edge");
  a_single_sample: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    SAMPLE_VALID_O |=> !SAMPLE_VALID_O [*3])
    else $error("more than one sample per frame");
  a_slave_linear: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    frame_edge && !MASTER_MODE_I && !FILTER_SELECT_PIN_I |=> !LOW_LATENCY_O)
    else $error("slave low pin did not select linear phase");
  a_slave_lowlat: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    frame_edge && !MASTER_MODE_I && FILTER_SELECT_PIN_I |=> LOW_LATENCY_O)
    else $error("slave high pin did not select low latency");
  a_master_linear: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    MASTER_MODE_I && frame_edge |=> !LOW_LATENCY_O)
    else $error("master mode left linear phase");
  a_default_set: assert property (@(posedge REF_CLK_I)
    $past(RESET_I) |-> !LOW_LATENCY_O)
    else $error("filter set not linear after reset");
  a_lowlat_path: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    frame_edge && st_reg.state == ADHC_ST_RUN && set_now == ADHC_SET_LOW
    |=> st_reg.dec[0] == $past(st_reg.acc[0]))
    else $error("low latency path not direct");
  a_linear_taps: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    frame_edge && st_reg.state == ADHC_ST_RUN && set_now == ADHC_SET_LIN && !wide_now
    |=> st_reg.dec[0] == AW'(($signed({$past(st_reg.acc[0][AW-1]), $past(st_reg.acc[0])})
        + 2 * $signed({$past(st_reg.h1[0][AW-1]), $past(st_reg.h1[0])})
        + $signed({$past(st_reg.h2[0][AW-1]), $past(st_reg.h2[0])})) >>> 2))
    else $error("linear phase taps wrong");
  a_wide_delay: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    frame_edge && st_reg.state == ADHC_ST_RUN && set_now == ADHC_SET_LIN && wide_now
    |=> st_reg.dec[0] == $past(st_reg.h1[0]) && WIDE_BAND_O)
    else $error("wide band path not flat delay");
  a_aligned: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    (&hpf_valid) || !(|hpf_valid))
    else $error("channels out of step");

  c_lowlat_out: cover property (@(posedge REF_CLK_I) disable iff (RESET_I)
    LOW_LATENCY_O && SAMPLE_VALID_O);
  c_wide_out: cover property (@(posedge REF_CLK_I) disable iff (RESET_I)
    WIDE_BAND_O && SAMPLE_VALID_O);
  c_master_out: cover property (@(posedge REF_CLK_I) disable iff (RESET_I)
    MASTER_MODE_I && FILTER_SELECT_PIN_I && SAMPLE_VALID_O);
endmodule : adhc_chain

// ==== verif/adhc_host_model.sv ====
// stand-in for the modulator and the serial-port host that paces the frames
// assumes the bench sets period_i (>= 5) and word_i before raising run_i
`timescale 1ns/100ps

module adhc_host_model (
  input  wire logic        clk_i,
  input  wire logic        run_i,
  input  wire logic [15:0] period_i,
  input  wire logic [31:0] word_i,
  output logic             frame_sync_o,
  output logic             mod_valid_o,
  output logic [31:0]      mod_data_o
);
  logic [15:0] cnt_reg;
  logic        started_reg;
  logic        tog_reg = 1'b0;

  // master-mode frame period stands in for the matching reference ratio
  always_ff @(posedge clk_i) begin
    tog_reg <= ~tog_reg;
    if (!run_i) begin
      cnt_reg      <= 16'h0;
      started_reg  <= 1'b0;
      frame_sync_o <= 1'b0;
      mod_valid_o  <= 1'b0;
      // idle data keeps moving so a stale word is never mistaken for real input
      mod_data_o   <= {32{tog_reg}};
    end else begin
      cnt_reg      <= (cnt_reg == period_i - 16'h1) ? 16'h0 : cnt_reg + 16'h1;
      frame_sync_o <= (cnt_reg == 16'h0);
      started_reg  <= started_reg | (cnt_reg == 16'h0);
      mod_valid_o  <= started_reg | (cnt_reg == 16'h0);
      mod_data_o   <= (started_reg | (cnt_reg == 16'h0)) ? word_i : {32{tog_reg}};
    end
  end
endmodule : adhc_host_model

// ==== verif/audio_decimation_hpf_chain_test.sv ====
// self-checking bench for the decimation and dc-removal chain
// assumes the chain at default widths: four channels, 8-bit words, 18-bit samples
`timescale 1ns/100ps

module audio_decimation_hpf_chain_test;
  import adhc_pkg::*;

  typedef struct {
    logic master;
    logic fsel;
    int   len;
    logic ll;
    logic wide;
  } adhc_row_t;

  adhc_row_t rows [6] = '{
    '{1'b0, 1'b0, 800, 1'b0, 1'b0},
    '{1'b0, 1'b1, 800, 1'b1, 1'b0},
    '{1'b1, 1'b1, 800, 1'b0, 1'b0},
    '{1'b1, 1'b0, 708, 1'b0, 1'b1},
    '{1'b0, 1'b1, 709, 1'b1, 1'b0},
    '{1'b0, 1'b1, 5,   1'b1, 1'b1}
  };
  int dval [4] = '{7, -5, 3, -1};

  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        master_mode = 1'b0;
  logic        filter_sel = 1'b0;
  logic        run = 1'b0;
  logic [15:0] period = 16'h0005;
  logic [31:0] word = {8'hff, 8'h03, 8'hfb, 8'h07};
  logic        frame_sync;
  logic        mod_valid;
  logic [31:0] mod_data;
  logic [71:0] samples;
  logic        sample_valid;
  logic        low_latency;
  logic        wide_band;
  logic        fs_prev;
  logic        cur_ll;
  logic        cur_wide;
  int          cur_len;
  int          fail_count = 0;
  int          check_count = 0;
  int          since, edges, got_n, s, x, y;
  int          h1 [4], h2 [4], x1 [4], y1 [4];

  always #4 ref_clk = ~ref_clk;

  adhc_chain u_adhc_chain (
    .REF_CLK_I           (ref_clk),
    .RESET_I             (reset),
    .MASTER_MODE_I       (master_mode),
    .FILTER_SELECT_PIN_I (filter_sel),
    .FRAME_SYNC_I        (frame_sync),
    .MOD_VALID_I         (mod_valid),
    .MOD_DATA_I          (mod_data),
    .SAMPLES_O           (samples),
    .SAMPLE_VALID_O      (sample_valid),
    .LOW_LATENCY_O       (low_latency),
    .WIDE_BAND_O         (wide_band)
  );

  adhc_host_model u_adhc_host_model (
    .clk_i        (ref_clk),
    .run_i        (run),
    .period_i     (period),
    .word_i       (word),
    .frame_sync_o (frame_sync),
    .mod_valid_o  (mod_valid),
    .mod_data_o   (mod_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // tolerance absorbs the fraction the one-pole feedback may keep below the integer
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input int tol);
    int diff;
    diff = $signed(got) - $signed(exp);
    check_count++;
    if ($isunknown(got) || diff > tol || diff < -tol) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  //////////////////////////////////////////////////////////////////////////////
  // reference model of the frame pipeline, run beside the design
  always @(posedge ref_clk) begin
    if (reset) begin
      since = 0;
      edges = 0;
      got_n = 0;
      fs_prev = 1'b0;
      for (int c = 0; c < 4; c++) begin
        h1[c] = 0; h2[c] = 0; x1[c] = 0; y1[c] = 0;
      end
    end else begin
      since++;
      if (frame_sync && !fs_prev) begin
        since = 0;
        edges++;
      end
      fs_prev = frame_sync;
      if (sample_valid === 1'b1) begin
        got_n++;
        check(since, 3, 0);
        check({31'h0, low_latency}, {31'h0, cur_ll}, 0);
        check({31'h0, wide_band}, {31'h0, cur_wide}, 0);
        for (int c = 0; c < 4; c++) begin
          s = cur_len * dval[c];
          x = cur_ll ? s : (cur_wide ? h1[c] : (s + 2 * h1[c] + h2[c]) >>> 2);
          y = x - x1[c] + y1[c] - ((y1[c] * 103) >>> 16);
          check(32'($signed(samples[c*18 +: 18])), y, 3);
          h2[c] = h1[c]; h1[c] = s; x1[c] = x; y1[c] = y;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic do_reset();
    run   <= 1'b0;
    reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check({28'h0, sample_valid, low_latency, wide_band, |samples}, 32'h0, 0);
    reset <= 1'b0;
  endtask : do_reset

  task automatic run_row(input adhc_row_t r);
    int n;
    do_reset();
    master_mode <= r.master;
    filter_sel  <= r.fsel;
    period      <= 16'(r.len);
    run         <= 1'b1;
    cur_ll   = r.ll;
    cur_wide = r.wide;
    cur_len  = r.len;
    n = 0;
    while (got_n < 3 && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 4000) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got_n, 3);
      wrap_up();
    end
    check(edges, got_n + 1, 0);
  endtask : run_row

  initial begin
    int w;
    for (int i = 0; i < 6; i++) begin
      run_row(rows[i]);
    end
    // reset lands one cycle after a frame edge, with a sum still in the pipeline
    run_row(rows[1]);
    w = 0;
    while (frame_sync !== 1'b1 && w < 1000) begin
      @(posedge ref_clk);
      w++;
    end
    if (w == 1000) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, w, 1);
      wrap_up();
    end
    @(posedge ref_clk);
    run_row(rows[5]);
    wrap_up();
  end
endmodule : audio_decimation_hpf_chain_test
